// File: ssq_map.svh
// timing counts and reset values for the supply sequencer
`ifndef SSQ_MAP_SVH
`define SSQ_MAP_SVH
`define SSQ_CLK_MHZ        100
`define SSQ_DLY1_NS        1000
`define SSQ_DLY2_NS        1000
`define SSQ_DLY3_NS        1000
`define SSQ_DLY4_NS        1000
`define SSQ_BLANK_NS       5000
`define SSQ_DLY1_CYC       ((`SSQ_DLY1_NS * `SSQ_CLK_MHZ + 999) / 1000)
`define SSQ_DLY2_CYC       ((`SSQ_DLY2_NS * `SSQ_CLK_MHZ + 999) / 1000)
`define SSQ_DLY3_CYC       ((`SSQ_DLY3_NS * `SSQ_CLK_MHZ + 999) / 1000)
`define SSQ_DLY4_CYC       ((`SSQ_DLY4_NS * `SSQ_CLK_MHZ + 999) / 1000)
`define SSQ_BLANK_CYC      ((`SSQ_BLANK_NS * `SSQ_CLK_MHZ) / 1000)
`define SSQ_ENABLES_RST    4'h0
`define SSQ_CNT_RST        16'h0000
`endif

// File: ssq_partner.sv
// regulator and shared fault line model facing the supply sequencer
module ssq_partner #(
    parameter int RAMP = 3                  // rail compliant RAMP+1 cycles after enable
) (
    input  wire logic       clk_i,          // clock
    input  wire logic       rst_n_i,        // async reset, active low
    input  wire logic [3:0] enable_i,       // rail enables from the sequencer
    input  wire logic [3:0] dead_i,         // rails that never ramp
    input  wire logic       drive_oe_i,     // sequencer pulls the line low
    input  wire logic       ext_pull_i,     // another party pulls the line low
    output logic [3:0]      monitor_o,      // comparator results
    output logic            fault_n_o       // resolved fault line level
);
    int cnt [4];
    // open drain with pull-up: any puller wins, otherwise the line idles high
    assign fault_n_o = !(drive_oe_i || ext_pull_i);
    // a rail needs time to ramp, but collapses as soon as its enable drops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        for (int k = 0; k < 4; k++)
        begin
            if (!rst_n_i || !enable_i[k] || dead_i[k])
            begin
                cnt[k]       <= 0;
                monitor_o[k] <= 1'b0;
            end
            else if (cnt[k] < RAMP)
                cnt[k] <= cnt[k] + 1;
            else
                monitor_o[k] <= 1'b1;
        end
    end
endmodule

// File: ssq_pkg.sv
// types shared by the supply sequencer
package ssq_pkg;
    typedef enum logic [2:0] {
        SSQ_WAIT  = 3'b000,   // awaiting_trigger_state
        SSQ_UP    = 3'b001,   // power-up in progress
        SSQ_ON    = 3'b010,   // rails_on_state
        SSQ_DOWN  = 3'b011,   // power-down in progress
        SSQ_FAULT = 3'b100    // fault_latched_state
    } ssq_state_e;

    typedef struct packed {
        ssq_state_e  state;
        logic [1:0]  step;        // current rail index
        logic        wait_pg;     // power-up: waiting for rail compliance
        logic [15:0] cnt;         // step timer
        logic [15:0] blank;       // blanking timer
        logic [3:0]  enables;
        logic        sequence_complete;
        logic        pgood;
        logic        fault_drv;
        logic [3:0]  mon_s1;
        logic [3:0]  mon_s2;
        logic [2:0]  trig_s1;     // up, down, direction
        logic [2:0]  trig_s2;
        logic [2:0]  trig_q;      // previous synchronised level, for edges
        logic        flt_s1;
        logic        flt_s2;
    } ssq_regs_s;
endpackage

// File: ssq_sequencer.sv
// four-rail supply sequencer state machine with shared fault line
// ===================================================================
// Overview of operation
// - up rising edge in wait starts power-up
// - down falling edge in on starts power-down
// - single-input variant uses direction for both
// - internal fault drives fault line low, latches
// - external low on fault line latches fault
// - four monitor comparators give rail compliance
// - enable 1 after delay 1 from trigger
// - sequence complete drops delay 1 after enable 1
// - enable 2 after delay 2 from rail 1
// - enable 1 drops delay 2 after enable 2
// - enable 3 after delay 3 from rail 2
// - enable 2 drops delay 3 after enable 3
// - enable 4 after delay 4 from rail 3
// - enable 4 drops at once on power-down
// - power good is AND of all four rails
// - rail missing compliance within blanking means fault
`include "ssq_map.svh"
module ssq_sequencer #(
    parameter bit          SINGLE_INPUT = 1'b0,           // 1: direction_in variant
    parameter logic [15:0] DLY1_CYC     = 16'(`SSQ_DLY1_CYC),
    parameter logic [15:0] DLY2_CYC     = 16'(`SSQ_DLY2_CYC),
    parameter logic [15:0] DLY3_CYC     = 16'(`SSQ_DLY3_CYC),
    parameter logic [15:0] DLY4_CYC     = 16'(`SSQ_DLY4_CYC),
    parameter logic [15:0] BLANK_CYC    = 16'(`SSQ_BLANK_CYC)
) (
    input  wire logic       clk_i,          // 100 MHz clock
    input  wire logic       rst_n_i,        // async reset, active low
    input  wire logic       up_i,           // dual variant power-up trigger pin
    input  wire logic       down_i,         // dual variant power-down trigger pin
    input  wire logic       direction_i,    // single variant trigger pin
    input  wire logic [3:0] supply_monitor_i, // comparator results, 1 = above reference
    input  wire logic       internal_fault_i, // internal fault request
    input  wire logic       fault_n_i,      // sensed fault line level
    output logic            fault_n_o,      // fault line drive value (always 0)
    output logic            fault_oe_o,     // high while pulling fault line low
    output logic [3:0]      supply_enable_o, // rail enables 1..4
    output logic            sequence_complete_o, // power-up finished
    output logic            power_good_o,   // all rails compliant
    output logic [2:0]      state_o         // state code for observation
);

    // ===============================================================
    // registers
    ssq_pkg::ssq_regs_s r_ff;
    ssq_pkg::ssq_regs_s nxt_r;

    // per-step delay select; power-up step n uses delay n+1
    function automatic logic [15:0] step_delay(input logic [1:0] s);
        case (s)
            2'h0:    step_delay = DLY1_CYC;
            2'h1:    step_delay = DLY2_CYC;
            2'h2:    step_delay = DLY3_CYC;
            default: step_delay = DLY4_CYC;
        endcase
    endfunction

    logic [3:0] rail_ok;
    logic       up_rise;
    logic       down_fall;
    logic       ext_fault;
    logic       any_fault;

    // ===============================================================
    // trigger edges, taken only from synchronised levels
    always_comb
    begin
        rail_ok   = r_ff.mon_s2;
        ext_fault = ~r_ff.flt_s2 & ~r_ff.fault_drv;
        if (SINGLE_INPUT)
        begin
            up_rise   = r_ff.trig_s2[2] & ~r_ff.trig_q[2];
            down_fall = ~r_ff.trig_s2[2] & r_ff.trig_q[2];
        end
        else
        begin
            up_rise   = r_ff.trig_s2[0] & ~r_ff.trig_q[0];
            down_fall = ~r_ff.trig_s2[1] & r_ff.trig_q[1];
        end
    end

    // ===============================================================
    // next-state logic
    always_comb
    begin
        nxt_r         = r_ff;
        nxt_r.mon_s1  = supply_monitor_i;
        nxt_r.mon_s2  = r_ff.mon_s1;
        nxt_r.trig_s1 = {direction_i, down_i, up_i};
        nxt_r.trig_s2 = r_ff.trig_s1;
        nxt_r.trig_q  = r_ff.trig_s2;
        nxt_r.flt_s1  = fault_n_i;
        nxt_r.flt_s2  = r_ff.flt_s1;
        nxt_r.pgood   = &rail_ok;
        // the blanking timer runs only while power-up is waiting for the current step's rail
        any_fault = internal_fault_i | ext_fault;
        if (r_ff.state == ssq_pkg::SSQ_UP && r_ff.wait_pg)
        begin
            if (r_ff.blank != 16'h0000)
                nxt_r.blank = r_ff.blank - 16'h0001;
        end
        if ((r_ff.state == ssq_pkg::SSQ_UP || r_ff.state == ssq_pkg::SSQ_ON)
            && ((r_ff.enables & ~rail_ok) != 4'h0) && r_ff.blank == 16'h0000
            && !(r_ff.state == ssq_pkg::SSQ_UP && r_ff.wait_pg && rail_ok[r_ff.step]))
            any_fault = 1'b1;
        case (r_ff.state)
            ssq_pkg::SSQ_WAIT:
            begin
                if (up_rise)
                begin
                    nxt_r.state   = ssq_pkg::SSQ_UP;
                    nxt_r.step    = 2'h0;
                    nxt_r.wait_pg = 1'b0;
                    nxt_r.cnt     = DLY1_CYC;
                end
            end
            ssq_pkg::SSQ_UP:
            begin
                if (!r_ff.wait_pg)
                begin
                    if (r_ff.cnt > 16'h0001)
                        nxt_r.cnt = r_ff.cnt - 16'h0001;
                    else
                    begin
                        // enable this step's rail after its delay
                        nxt_r.enables[r_ff.step] = 1'b1;
                        nxt_r.wait_pg            = 1'b1;
                        nxt_r.blank              = BLANK_CYC;
                    end
                end
                else if (rail_ok[r_ff.step])
                begin
                    nxt_r.wait_pg = 1'b0;
                    nxt_r.blank   = 16'h0000;    // rail is in: a dropout faults at once, except during a later rail's blanking
                    if (r_ff.step == 2'h3)
                    begin
                        nxt_r.state    = ssq_pkg::SSQ_ON;
                        nxt_r.sequence_complete = 1'b1;
                    end
                    else
                    begin
                        nxt_r.step = r_ff.step + 2'h1;
                        nxt_r.cnt  = step_delay(r_ff.step + 2'h1);
                    end
                end
            end
            ssq_pkg::SSQ_ON:
            begin
                if (down_fall)
                begin
                    nxt_r.state      = ssq_pkg::SSQ_DOWN;
                    nxt_r.enables[3] = 1'b0;
                    nxt_r.step       = 2'h3;
                    nxt_r.cnt        = DLY4_CYC;
                end
            end
            ssq_pkg::SSQ_DOWN:
            begin
                // step k: enable k+1 is already low; count delay k+1 then drop the next
                if (r_ff.cnt > 16'h0001)
                    nxt_r.cnt = r_ff.cnt - 16'h0001;
                else if (r_ff.step == 2'h0)
                begin
                    nxt_r.sequence_complete = 1'b0;
                    nxt_r.state    = ssq_pkg::SSQ_WAIT;
                end
                else
                begin
                    nxt_r.enables[r_ff.step - 2'h1] = 1'b0;
                    nxt_r.step = r_ff.step - 2'h1;
                    nxt_r.cnt  = step_delay(r_ff.step - 2'h1);
                end
            end
            default:
            begin
                // latched until the line is released, the internal fault is gone and the up and direction triggers are low
                if (!ext_fault && !internal_fault_i && !r_ff.trig_s2[0]
                    && !r_ff.trig_s2[2] && !r_ff.fault_drv)
                    nxt_r.state = ssq_pkg::SSQ_WAIT;
                nxt_r.fault_drv = 1'b0;
            end
        endcase
        if (any_fault && r_ff.state != ssq_pkg::SSQ_FAULT)
        begin
            nxt_r.state     = ssq_pkg::SSQ_FAULT;
            nxt_r.enables   = 4'h0;
            nxt_r.sequence_complete  = 1'b0;
            nxt_r.fault_drv = ~ext_fault;
        end
    end

    // ===============================================================
    // state register; constants only under reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r_ff           <= '0;
            r_ff.state     <= ssq_pkg::SSQ_WAIT;
            r_ff.enables   <= `SSQ_ENABLES_RST;
            r_ff.cnt       <= `SSQ_CNT_RST;
            r_ff.mon_s1    <= 4'h0;
            r_ff.flt_s1    <= 1'b1;
            r_ff.flt_s2    <= 1'b1;
        end
        else
            r_ff <= nxt_r;
    end

    // ===============================================================
    // outputs straight from flip-flops, except fault_n_o tied to 0
    assign fault_n_o           = 1'b0;
    assign fault_oe_o          = r_ff.fault_drv;
    assign supply_enable_o     = r_ff.enables;
    assign sequence_complete_o = r_ff.sequence_complete;
    assign power_good_o        = r_ff.pgood;
    assign state_o             = r_ff.state;

    // ===============================================================
    // checks
    property p_up_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_WAIT && up_rise && !any_fault)
            |=> (r_ff.state == ssq_pkg::SSQ_UP);
    endproperty
    a_up_start: assert property (p_up_start) else $error("power-up did not start");

    property p_down_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_ON && down_fall && !any_fault)
            |=> (r_ff.state == ssq_pkg::SSQ_DOWN && !supply_enable_o[3]);
    endproperty
    a_down_start: assert property (p_down_start) else $error("power-down start wrong");

    property p_no_up_elsewhere;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_ON) |=> (r_ff.state != ssq_pkg::SSQ_UP);
    endproperty
    a_no_up_elsewhere: assert property (p_no_up_elsewhere) else $error("stray power-up");

    property p_int_fault;
        @(posedge clk_i) disable iff (!rst_n_i)
        (internal_fault_i && r_ff.state != ssq_pkg::SSQ_FAULT && !ext_fault)
            |=> (fault_oe_o && r_ff.state == ssq_pkg::SSQ_FAULT);
    endproperty
    a_int_fault: assert property (p_int_fault) else $error("internal fault not driven");

    property p_ext_fault;
        @(posedge clk_i) disable iff (!rst_n_i)
        ext_fault |=> (r_ff.state == ssq_pkg::SSQ_FAULT && supply_enable_o == 4'h0);
    endproperty
    a_ext_fault: assert property (p_ext_fault) else $error("external fault missed");

    property p_pgood;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (power_good_o == &$past(r_ff.mon_s2));
    endproperty
    a_pgood: assert property (p_pgood) else $error("power good mismatch");

    property p_en1_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_WAIT && up_rise && !any_fault)
            |=> !supply_enable_o[0] [*2];
    endproperty
    a_en1_delay: assert property (p_en1_delay) else $error("enable 1 early");

    property p_seq_drop;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(sequence_complete_o) |-> (supply_enable_o == 4'h0);
    endproperty
    a_seq_drop: assert property (p_seq_drop) else $error("complete dropped early");

    property p_down_order;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_DOWN && $fell(supply_enable_o[0]))
            |-> (supply_enable_o[3:1] == 3'h0);
    endproperty
    a_down_order: assert property (p_down_order) else $error("down order wrong");

    property p_drop_fault;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_ON && ((r_ff.enables & ~rail_ok) != 4'h0))
            |=> (r_ff.state == ssq_pkg::SSQ_FAULT);
    endproperty
    a_drop_fault: assert property (p_drop_fault) else $error("rail loss not faulted");

    property p_fault_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (any_fault && r_ff.state != ssq_pkg::SSQ_FAULT)
            |=> (supply_enable_o == 4'h0 && !sequence_complete_o);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("outputs left on in fault");

    property p_up_order;
        @(posedge clk_i) disable iff (!rst_n_i)
        (r_ff.state == ssq_pkg::SSQ_UP && $rose(supply_enable_o[1]))
            |-> supply_enable_o[0];
    endproperty
    a_up_order: assert property (p_up_order) else $error("enable 2 before enable 1");

    c_power_up:   cover property (@(posedge clk_i) $rose(sequence_complete_o));
    c_power_down: cover property (@(posedge clk_i) $fell(sequence_complete_o)
                                  && r_ff.state == ssq_pkg::SSQ_WAIT);
    c_fault:      cover property (@(posedge clk_i) $rose(fault_oe_o));
endmodule

// File: tb_top.sv
// self-checking bench for the supply sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D [4] = '{4, 5, 6, 7};
    localparam int BLANK = 20;
    logic       clk_i, rst_n_i, up_i, down_i, direction_i, int_flt, ext_pull, oe, done, pg;
    logic       line_n;
    logic [3:0] dead, mon, en;
    logic [2:0] state;
    logic [8:0] obs;
    int         err_total, checks;
    assign obs = {mon, done, en};
    // ===============================================
    // design and far side
    ssq_sequencer #(.DLY1_CYC(16'h0004), .DLY2_CYC(16'h0005), .DLY3_CYC(16'h0006),
        .DLY4_CYC(16'h0007), .BLANK_CYC(16'h0014)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .up_i(up_i), .down_i(down_i), .direction_i(direction_i), .supply_monitor_i(mon),
        .internal_fault_i(int_flt), .fault_n_i(line_n), .fault_n_o(), .fault_oe_o(oe),
        .supply_enable_o(en), .sequence_complete_o(done), .power_good_o(pg), .state_o(state));
    ssq_partner far (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(en),
        .dead_i(dead), .drive_oe_i(oe), .ext_pull_i(ext_pull), .monitor_o(mon),
        .fault_n_o(line_n));
    // ===============================================
    // helpers
    task automatic bad(input string m);
        err_total++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic conclude();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait on one observed bit, n counts the edges taken
    task automatic wait_bit(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (obs[i] !== v)
        begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > lim)
            begin
                bad("wait on output ran out");
                conclude();
            end
        end
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim, output int n);
        n = 0;
        while (state !== s)
        begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > lim)
            begin
                bad("wait on state ran out");
                conclude();
            end
        end
    endtask
    // ===============================================
    // scenarios
    task automatic power_up();
        int n;
        @(posedge clk_i);
        up_i <= 1'b0;
        @(posedge clk_i);
        up_i <= 1'b1;
        #1;
        wait_bit(0, 1'b1, 40, n);
        checks++;
        if (n < D[0] || n > D[0] + 6) bad("first enable delay");
        for (int k = 1; k < 4; k++)
        begin
            wait_bit(k + 4, 1'b1, 20, n);
            wait_bit(k, 1'b1, 30, n);
            checks++;
            if (n < D[k] || n > D[k] + 4) bad("enable delay after rail");
            checks++;
            if (en !== 4'((1 << (k + 1)) - 1)) bad("enable order");
        end
        wait_bit(4, 1'b1, 20, n);
        repeat (4) @(posedge clk_i);
        #1;
        checks++;
        if (state !== ssq_pkg::SSQ_ON || pg !== 1'b1) bad("not on with power good");
    endtask
    task automatic power_down();
        int n;
        @(posedge clk_i);
        down_i <= 1'b0;
        #1;
        wait_bit(3, 1'b0, 10, n);
        checks++;
        if (n > 5 || en[2:0] !== 3'h7) bad("last enable not dropped at once");
        for (int j = 2; j >= -1; j--)
        begin
            wait_bit(j >= 0 ? j : 4, 1'b0, 30, n);
            checks++;
            if (n < D[j + 1] || n > D[j + 1] + 2) bad("power-down gap");
        end
        wait_st(ssq_pkg::SSQ_WAIT, 4, n);
        @(posedge clk_i);
        down_i <= 1'b1;
    endtask
    // the dual variant must ignore a direction edge as well as a down edge in wait
    task automatic refuse_idle();
        @(posedge clk_i);
        down_i      <= 1'b0;
        direction_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        down_i      <= 1'b1;
        direction_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        checks++;
        if (state !== ssq_pkg::SSQ_WAIT || en !== 4'h0) bad("down left wait");
        checks++;
        if (pg !== 1'b0) bad("power good with rails off");
    endtask
    task automatic refuse_on();
        @(posedge clk_i);
        up_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        up_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        #1;
        checks++;
        if (state !== ssq_pkg::SSQ_ON || en !== 4'hF) bad("up edge moved on state");
    endtask
    task automatic recover();
        int n;
        @(posedge clk_i);
        up_i     <= 1'b0;
        int_flt  <= 1'b0;
        ext_pull <= 1'b0;
        dead     <= 4'h0;
        #1;
        wait_st(ssq_pkg::SSQ_WAIT, 40, n);
        checks++;
        if (en !== 4'h0 || done !== 1'b0) bad("fault left outputs on");
    endtask
    task automatic fault_case(input bit inner);
        int   n;
        logic seen;
        seen = 1'b0;
        @(posedge clk_i);
        if (inner)
            int_flt <= 1'b1;
        else
            ext_pull <= 1'b1;
        for (n = 0; n < 8 && state !== ssq_pkg::SSQ_FAULT; n++)
        begin
            @(posedge clk_i);
            #1;
            seen = seen | oe;
        end
        repeat (2) @(posedge clk_i);
        #1;
        seen = seen | oe;
        checks++;
        if (state !== ssq_pkg::SSQ_FAULT || en !== 4'h0) bad("fault not latched");
        checks++;
        if (seen !== inner) bad("fault line drive wrong");
        recover();
    endtask
    // a rail lost in the on state faults at once, with no blanking grace
    task automatic drop_rail();
        int n;
        @(posedge clk_i);
        dead <= 4'h2;
        #1;
        wait_st(ssq_pkg::SSQ_FAULT, 8, n);
        checks++;
        if (n < 3 || en !== 4'h0 || oe !== 1'b1) bad("rail loss not faulted");
        recover();
    endtask
    task automatic blanking();
        int n;
        @(posedge clk_i);
        dead    <= 4'h4;
        up_i    <= 1'b1;
        #1;
        wait_bit(2, 1'b1, 80, n);
        wait_st(ssq_pkg::SSQ_FAULT, 60, n);
        checks++;
        if (n < BLANK || n > BLANK + 6) bad("blanking time");
        checks++;
        if (en !== 4'h0) bad("enables held in fault");
        recover();
    endtask
    // ===============================================
    // clock, reset and scenario order
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        err_total = 0;
        checks = 0;
        rst_n_i = 1'b0;
        up_i = 1'b0;
        down_i = 1'b1;
        direction_i = 1'b0;
        int_flt = 1'b0;
        ext_pull = 1'b0;
        dead = 4'h0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        refuse_idle();
        power_up();
        refuse_on();
        power_down();
        power_up();
        fault_case(1'b1);
        power_up();
        fault_case(1'b0);
        power_up();
        drop_rail();
        blanking();
        conclude();
    end
endmodule
